// File: rtl/opmc_top.sv
`timescale 1ns/1ns
`default_nettype none
module opmc_top (
   input  wire logic        hclk,                // System clock, 25 MHz
   input  wire logic        hresetn,             // Async reset, low
   input  wire logic        hsel,                // AHB slave select
   input  wire logic [31:0] haddr,               // AHB address
   input  wire logic [1:0]  htrans,              // AHB transfer type
   input  wire logic        hwrite,              // AHB write
   input  wire logic [2:0]  hsize,               // AHB size
   input  wire logic [31:0] hwdata,              // AHB write data
   input  wire logic        hready,              // AHB bus ready
   output logic      [31:0] hrdata,              // AHB read data
   output logic             hreadyout,           // AHB slave ready
   output logic             hresp,               // AHB response
   input  wire logic        idle_pin,            // Idle-control pin
   input  wire logic [1:0]  direct_input_pin,    // Direct input pins
   input  wire logic        vs_uv_flag,          // Analog supply undervoltage
   input  wire logic        vdd_uv_flag,         // Digital supply undervoltage
   input  wire logic        vs_op_flag,          // Analog supply operative
   input  wire logic        vdd_lop_flag,        // Digital supply above low power
   input  wire logic [7:0]  channel_error_event, // Per-channel fault level
   output logic      [7:0]  channel_on,          // Channel drive
   output logic      [1:0]  mode_status          // Mode field
);
   logic [opmc_pkg::NSYNC-1:0] sync_q;
   logic                       idle_s, vs_uv_s, vdd_uv_s, vs_op_s, vdd_lop_s;
   logic [opmc_pkg::NIN-1:0]   in_s;
   logic [opmc_pkg::NCH-1:0]   err_evt_s;
   logic                       pwr_on, any_in;
   logic                       idle_m_r, idle_q_r;
   opmc_pkg::opmc_mode_t       mode;

   opmc_sync #(
      .W (opmc_pkg::NSYNC)
   ) i_opmc_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({channel_error_event, direct_input_pin, vdd_lop_flag, vs_op_flag, vdd_uv_flag,
                 vs_uv_flag}),
      .q       (sync_q)
   );

   assign vs_uv_s   = sync_q[0];
   assign vdd_uv_s  = sync_q[1];
   assign vs_op_s   = sync_q[2];
   assign vdd_lop_s = sync_q[3];
   assign in_s      = sync_q[5:4];
   assign err_evt_s = sync_q[13:6];
   assign idle_s    = idle_q_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idle_m_r <= 1'b0;
         idle_q_r <= 1'b0;
      end else begin
         idle_m_r <= idle_pin;
         idle_q_r <= idle_m_r;
      end
   end

   // Power-up is only recognised with a supply level and a pin pulled high
   assign pwr_on = vs_op_s || vdd_lop_s;
   assign any_in = |in_s;

   logic [7:0] out_cmd_r, out_cmd_nxt;
   logic       stay_r, stay_nxt;
   logic [7:0] map0_r, map0_nxt, map1_r, map1_nxt;
   logic [7:0] err_r, err_nxt;

   opmc_mode_fsm i_opmc_mode_fsm (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pwr_on  (pwr_on && (any_in || idle_s)),
      .idle    (idle_s),
      .any_in  (any_in),
      .cmd_any (|out_cmd_r),
      .stay    (stay_r),
      .vdd_uv  (vdd_uv_s),
      .mode    (mode)
   );

   // AHB address phase capture; zero wait states, always OKAY
   logic       wen_r, wen_nxt, ren_r, ren_nxt;
   logic [7:0] addr_r, addr_nxt;
   logic       valid;

   assign valid = hsel && htrans[1] && hready && (hsize == opmc_pkg::HSIZE_WORD);

   always_comb begin
      wen_nxt  = valid && hwrite;
      ren_nxt  = valid && !hwrite;
      addr_nxt = valid ? {haddr[7:2], 2'b00} : addr_r;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wen_r  <= 1'b0;
         ren_r  <= 1'b0;
         addr_r <= 8'h00;
      end else begin
         wen_r  <= wen_nxt;
         ren_r  <= ren_nxt;
         addr_r <= addr_nxt;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   logic wr_ok, rd_ok, rst_cmd, reg_clr;

   // Limp and sleep never take writes; digital undervoltage blocks all access
   assign wr_ok = !vdd_uv_s && (mode == opmc_pkg::M_IDLE || mode == opmc_pkg::M_ACTIVE);
   assign rd_ok = !vdd_uv_s && (mode != opmc_pkg::M_SLEEP);
   assign rst_cmd = wen_r && wr_ok && addr_r == opmc_pkg::ADDR_HWCR && hwdata[opmc_pkg::REGISTER_RESET_COMMAND_BIT];
   assign reg_clr = vdd_uv_s || !idle_s || mode == opmc_pkg::M_SLEEP || rst_cmd;

   always_comb begin
      out_cmd_nxt = out_cmd_r;
      stay_nxt    = stay_r;
      map0_nxt    = map0_r;
      map1_nxt    = map1_r;
      if (reg_clr) begin
         out_cmd_nxt = opmc_pkg::OUT_RST;
         stay_nxt    = opmc_pkg::ACT_RST;
         map0_nxt    = opmc_pkg::MAP0_RST;
         map1_nxt    = opmc_pkg::MAP1_RST;
      end else if (wen_r && wr_ok) begin
         case (addr_r)
            opmc_pkg::ADDR_OUT:  out_cmd_nxt = hwdata[7:0];
            opmc_pkg::ADDR_HWCR: stay_nxt    = hwdata[opmc_pkg::STAY_ACTIVE_BIT_BIT];
            opmc_pkg::ADDR_MAP0: map0_nxt    = hwdata[7:0];
            opmc_pkg::ADDR_MAP1: map1_nxt    = hwdata[7:0];
            default:             out_cmd_nxt = out_cmd_r;
         endcase
      end
   end

   // Error flags survive register resets; a new fault beats a clear
   logic [7:0] err_clr, err_set;

   always_comb begin
      err_clr = (wen_r && wr_ok && addr_r == opmc_pkg::ADDR_ERR) ? hwdata[7:0] : 8'h00;
      err_set = (mode == opmc_pkg::M_ACTIVE || mode == opmc_pkg::M_LIMP) ? err_evt_s : 8'h00;
      err_nxt = (err_r & ~err_clr) | err_set;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_cmd_r <= opmc_pkg::OUT_RST;
         stay_r    <= opmc_pkg::ACT_RST;
         map0_r    <= opmc_pkg::MAP0_RST;
         map1_r    <= opmc_pkg::MAP1_RST;
         err_r     <= opmc_pkg::ERR_RST;
      end else begin
         out_cmd_r <= out_cmd_nxt;
         stay_r    <= stay_nxt;
         map0_r    <= map0_nxt;
         map1_r    <= map1_nxt;
         err_r     <= err_nxt;
      end
   end

   logic [31:0] stat_word;

   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[opmc_pkg::STAT_MODE_LSB +: 2] = mode;
      stat_word[opmc_pkg::STAT_PWR_BIT]       = pwr_on;
      stat_word[opmc_pkg::STAT_VDDUV_BIT]     = vdd_uv_s;
      stat_word[opmc_pkg::STAT_VSUV_BIT]      = vs_uv_s;
      hrdata = 32'h0000_0000;
      if (ren_r && rd_ok) begin
         case (addr_r)
            opmc_pkg::ADDR_OUT:  hrdata = {24'h00_0000, out_cmd_r};
            opmc_pkg::ADDR_HWCR: hrdata = {31'h0000_0000, stay_r};
            opmc_pkg::ADDR_MAP0: hrdata = {24'h00_0000, map0_r};
            opmc_pkg::ADDR_MAP1: hrdata = {24'h00_0000, map1_r};
            opmc_pkg::ADDR_STAT: hrdata = stat_word;
            opmc_pkg::ADDR_ERR:  hrdata = {24'h00_0000, err_r};
            default:             hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Channel drive; pins stay usable unless both supplies are low
   logic [7:0] chan_r, chan_nxt, pin_map;
   logic       pin_ok;

   always_comb begin
      pin_map = (in_s[0] ? map0_r : 8'h00) | (in_s[1] ? map1_r : 8'h00);
      pin_ok  = !(vs_uv_s && vdd_uv_s);
      case (mode)
         opmc_pkg::M_ACTIVE: chan_nxt = (vdd_uv_s ? 8'h00 : out_cmd_r) | (pin_ok ? pin_map : 8'h00);
         opmc_pkg::M_LIMP:   chan_nxt = pin_ok ? pin_map : 8'h00;
         default:            chan_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         chan_r <= 8'h00;
      else
         chan_r <= chan_nxt;
   end

   assign channel_on  = chan_r;
   assign mode_status = mode;

   property p_sleep_off;
      @(posedge hclk) disable iff (!hresetn)
      mode == opmc_pkg::M_SLEEP |=> chan_r == 8'h00 && map0_r == opmc_pkg::MAP0_RST;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("Sleep left channels or maps");

   property p_idle_off;
      @(posedge hclk) disable iff (!hresetn)
      mode == opmc_pkg::M_IDLE |=> chan_r == 8'h00;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("Channel on in idle");

   property p_idle_write;
      @(posedge hclk) disable iff (!hresetn)
      wen_r && addr_r == opmc_pkg::ADDR_MAP1 && idle_s && !vdd_uv_s && mode == opmc_pkg::M_IDLE
      |=> map1_r == $past(hwdata[7:0]);
   endproperty
   a_idle_write: assert property (p_idle_write) else $error("Idle write lost");

   property p_err_kept;
      @(posedge hclk) disable iff (!hresetn)
      reg_clr && !(wen_r && addr_r == opmc_pkg::ADDR_ERR) |=> (err_r & $past(err_r)) == $past(err_r);
   endproperty
   a_err_kept: assert property (p_err_kept) else $error("Error flag lost on reset");

   property p_limp_pins;
      @(posedge hclk) disable iff (!hresetn)
      mode == opmc_pkg::M_LIMP && !any_in ##1 mode == opmc_pkg::M_LIMP |-> chan_r == 8'h00;
   endproperty
   a_limp_pins: assert property (p_limp_pins) else $error("Limp drive without pin");

   property p_uv_both;
      @(posedge hclk) disable iff (!hresetn)
      vs_uv_s && vdd_uv_s |=> chan_r == 8'h00;
   endproperty
   a_uv_both: assert property (p_uv_both) else $error("Drive with both supplies low");

   property p_reg_clr;
      @(posedge hclk) disable iff (!hresetn)
      reg_clr |=> out_cmd_r == opmc_pkg::OUT_RST && stay_r == opmc_pkg::ACT_RST;
   endproperty
   a_reg_clr: assert property (p_reg_clr) else $error("Registers not reset");

   property p_zero_map_active;
      @(posedge hclk) disable iff (!hresetn)
      (pwr_on && idle_s && any_in && map0_r == 8'h00 && map1_r == 8'h00)[*8] |-> mode == opmc_pkg::M_ACTIVE;
   endproperty
   a_zero_map_active: assert property (p_zero_map_active) else $error("Zero maps blocked active");

   property p_err_idle;
      @(posedge hclk) disable iff (!hresetn)
      mode == opmc_pkg::M_IDLE && !(wen_r && addr_r == opmc_pkg::ADDR_ERR) |=> err_r == $past(err_r);
   endproperty
   a_err_idle: assert property (p_err_idle) else $error("Error flags changed in idle");

   property p_limp_read;
      @(posedge hclk) disable iff (!hresetn)
      ren_r && mode == opmc_pkg::M_LIMP && !vdd_uv_s && addr_r == opmc_pkg::ADDR_MAP0 |-> hrdata == {24'h00_0000, map0_r};
   endproperty
   a_limp_read: assert property (p_limp_read) else $error("Limp read refused");

   property p_uv_no_read;
      @(posedge hclk) disable iff (!hresetn)
      ren_r && vdd_uv_s |-> hrdata == 32'h0000_0000;
   endproperty
   a_uv_no_read: assert property (p_uv_no_read) else $error("Read served in undervoltage");

   property p_stat_mode;
      @(posedge hclk) disable iff (!hresetn)
      ren_r && rd_ok && addr_r == opmc_pkg::ADDR_STAT |-> hrdata[1:0] == mode;
   endproperty
   a_stat_mode: assert property (p_stat_mode) else $error("Status mode field wrong");
endmodule
`default_nettype wire

// File: rtl/opmc_pkg.sv
`default_nettype none
package opmc_pkg;
   localparam logic [7:0] ADDR_OUT  = 8'h00;
   localparam logic [7:0] ADDR_HWCR = 8'h04;
   localparam logic [7:0] ADDR_MAP0 = 8'h08;
   localparam logic [7:0] ADDR_MAP1 = 8'h0C;
   localparam logic [7:0] ADDR_STAT = 8'h10;
   localparam logic [7:0] ADDR_ERR  = 8'h14;
   localparam int STAY_ACTIVE_BIT_BIT  = 0;
   localparam int REGISTER_RESET_COMMAND_BIT  = 1;
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_PWR_BIT  = 2;
   localparam int STAT_VDDUV_BIT = 3;
   localparam int STAT_VSUV_BIT = 4;
   localparam logic [7:0] OUT_RST  = 8'h00;
   localparam logic [7:0] MAP0_RST = 8'h04;
   localparam logic [7:0] MAP1_RST = 8'h08;
   localparam logic [7:0] ERR_RST  = 8'h00;
   localparam logic       ACT_RST  = 1'b0;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam int CLK_NS      = 40;
   localparam int TRANS_NS    = 200;
   localparam int TRANS_CYC_I = (TRANS_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] TRANS_CYC = TRANS_CYC_I[2:0];
   localparam int NCH = 8;
   localparam int NIN = 2;
   localparam int NSYNC = 14;
   typedef enum logic [1:0] {
      M_SLEEP  = 2'b00,
      M_LIMP   = 2'b01,
      M_ACTIVE = 2'b10,
      M_IDLE   = 2'b11
   } opmc_mode_t;
endpackage
`default_nettype wire

// File: rtl/opmc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module opmc_sync #(
   parameter int W = 1
) (
   input  wire logic         hclk,    // System clock
   input  wire logic         hresetn, // Async reset, low
   input  wire logic [W-1:0] d,       // Asynchronous levels
   output logic      [W-1:0] q        // Synchronised levels
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r <= '0;
         q_r    <= '0;
      end else begin
         meta_r <= d;
         q_r    <= meta_r;
      end
   end

   assign q = q_r;
endmodule
`default_nettype wire

// File: rtl/opmc_mode_fsm.sv
`timescale 1ns/1ns
`default_nettype none
module opmc_mode_fsm (
   input  wire logic                hclk,    // System clock
   input  wire logic                hresetn, // Async reset, low
   input  wire logic                pwr_on,  // Internal power-on
   input  wire logic                idle,    // Idle-control pin level
   input  wire logic                any_in,  // Any direct input high
   input  wire logic                cmd_any, // Any channel command bit set
   input  wire logic                stay,    // Stay-active bit
   input  wire logic                vdd_uv,  // Digital supply undervoltage
   output var opmc_pkg::opmc_mode_t mode     // Current mode
);
   opmc_pkg::opmc_mode_t mode_r, mode_nxt, pend_r, pend_nxt, tgt;
   logic [2:0]           cnt_r, cnt_nxt;
   logic                 entering;

   always_comb begin
      if (!pwr_on)
         tgt = opmc_pkg::M_SLEEP;
      else if (!idle)
         tgt = any_in ? opmc_pkg::M_LIMP : opmc_pkg::M_SLEEP;
      else if (any_in)
         tgt = opmc_pkg::M_ACTIVE;
      else if (!vdd_uv && (cmd_any || (mode_r == opmc_pkg::M_ACTIVE && stay)))
         tgt = opmc_pkg::M_ACTIVE;
      else
         tgt = opmc_pkg::M_IDLE;
      entering = (tgt == opmc_pkg::M_ACTIVE) || (tgt == opmc_pkg::M_LIMP);
      mode_nxt = mode_r;
      pend_nxt = tgt;
      cnt_nxt  = 3'h0;
      // Exits are immediate for safety; entries pay the transition latency
      if (tgt == mode_r)
         mode_nxt = mode_r;
      else if (!entering)
         mode_nxt = tgt;
      else if (tgt == pend_r) begin
         if (cnt_r == 3'(opmc_pkg::TRANS_CYC - 3'h1))
            mode_nxt = tgt;
         else
            cnt_nxt = 3'(cnt_r + 3'h1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_r <= opmc_pkg::M_SLEEP;
         pend_r <= opmc_pkg::M_SLEEP;
         cnt_r  <= 3'h0;
      end else begin
         mode_r <= mode_nxt;
         pend_r <= pend_nxt;
         cnt_r  <= cnt_nxt;
      end
   end

   assign mode = mode_r;

   property p_entry_latency;
      @(posedge hclk) disable iff (!hresetn)
      (mode_r != $past(mode_r)) && (mode_r == opmc_pkg::M_ACTIVE || mode_r == opmc_pkg::M_LIMP)
      |-> $past(cnt_r) == 3'(opmc_pkg::TRANS_CYC - 3'h1);
   endproperty
   a_entry_latency: assert property (p_entry_latency) else $error("Entry without latency");

   property p_no_power;
      @(posedge hclk) disable iff (!hresetn)
      !pwr_on |=> mode_r == opmc_pkg::M_SLEEP;
   endproperty
   a_no_power: assert property (p_no_power) else $error("Not asleep without power");

   property p_enter_active;
      @(posedge hclk) disable iff (!hresetn)
      (pwr_on && idle && any_in)[*8] |-> mode_r == opmc_pkg::M_ACTIVE;
   endproperty
   a_enter_active: assert property (p_enter_active) else $error("Active not reached");

   property p_return_idle;
      @(posedge hclk) disable iff (!hresetn)
      mode_r == opmc_pkg::M_ACTIVE && pwr_on && idle && !any_in && !stay && !cmd_any
      |=> mode_r == opmc_pkg::M_IDLE;
   endproperty
   a_return_idle: assert property (p_return_idle) else $error("Active did not return to idle");

   property p_stay_active;
      @(posedge hclk) disable iff (!hresetn)
      mode_r == opmc_pkg::M_ACTIVE && pwr_on && idle && stay && !vdd_uv
      |=> mode_r == opmc_pkg::M_ACTIVE;
   endproperty
   a_stay_active: assert property (p_stay_active) else $error("Left active while held");

   property p_vdd_uv_idle;
      @(posedge hclk) disable iff (!hresetn)
      mode_r == opmc_pkg::M_ACTIVE && pwr_on && idle && vdd_uv && !any_in
      |=> mode_r == opmc_pkg::M_IDLE;
   endproperty
   a_vdd_uv_idle: assert property (p_vdd_uv_idle) else $error("Undervoltage kept active");

   property p_enter_limp;
      @(posedge hclk) disable iff (!hresetn)
      (pwr_on && !idle && any_in)[*8] |-> mode_r == opmc_pkg::M_LIMP && mode_r == 2'b01;
   endproperty
   a_enter_limp: assert property (p_enter_limp) else $error("Limp not reached");

   property p_sleep;
      @(posedge hclk) disable iff (!hresetn)
      pwr_on && !idle && !any_in |=> mode_r == opmc_pkg::M_SLEEP;
   endproperty
   a_sleep: assert property (p_sleep) else $error("Not asleep with pins low");
endmodule
`default_nettype wire

// File: sim/opmc_host.sv
`timescale 1ns/1ns
`default_nettype none
module opmc_host (
   input  wire logic        hclk,        // Clock
   input  wire logic        hreadyout,   // Slave ready
   input  wire logic [31:0] hrdata,      // Read data
   input  wire logic [1:0]  mode_status, // Observed mode
   output logic             hsel,        // Select
   output logic      [31:0] haddr,       // Address
   output logic      [1:0]  htrans,      // Transfer type
   output logic             hwrite,      // Write
   output logic      [2:0]  hsize,       // Size
   output logic      [31:0] hwdata,      // Write data
   output logic             idle_pin,    // Idle-control pin
   output logic      [1:0]  din          // Direct inputs
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
      idle_pin = 1'b0;
      din = 2'h0;
   end
   // Called just after a rising edge; returns just after one
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= opmc_pkg::HSIZE_WORD;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      // Released lines must not keep their last value
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      haddr <= ~{24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      hwdata <= ~d;
   endtask
   task automatic pins(input logic i, input logic [1:0] n);
      idle_pin <= i;
      din <= n;
   endtask
   // No command is issued while a mode change is under way
   task automatic settle(input logic [1:0] e, output logic ok);
      ok = 1'b0;
      for (int n = 0; n < 40 && !ok; n++) begin
         @(negedge hclk) ok = (mode_status === e);
      end
      @(posedge hclk);
   endtask
endmodule
`default_nettype wire

// File: sim/test_operation_mode_controller.sv
`timescale 1ns/1ns
`default_nettype none
module test_operation_mode_controller;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   wire  [31:0] hrdata;
   wire         hreadyout;
   wire         hresp;
   logic        idle_pin;
   logic [1:0]  din;
   logic        vs_uv, vdd_uv, vs_op, vdd_lop;
   logic [7:0]  evt;
   wire  [7:0]  channel_on;
   wire  [1:0]  mode_status;
   int          fail_count, samples_checked, cyc;
   logic [31:0] x;
   logic [7:0]  m_out, m_map0, m_map1, m_err, pm;
   logic        m_act;
   logic [1:0]  m_mode;
   opmc_top i_opmc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .idle_pin(idle_pin), .direct_input_pin(din),
      .vs_uv_flag(vs_uv), .vdd_uv_flag(vdd_uv), .vs_op_flag(vs_op), .vdd_lop_flag(vdd_lop),
      .channel_error_event(evt), .channel_on(channel_on), .mode_status(mode_status));
   opmc_host u_host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .mode_status(mode_status),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .idle_pin(idle_pin), .din(din));
   always #20 hclk = ~hclk;
   task automatic complete_run;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("Error t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   function automatic logic [31:0] rnd();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   function automatic void regs_def();
      m_out = opmc_pkg::OUT_RST;
      m_act = opmc_pkg::ACT_RST;
      m_map0 = opmc_pkg::MAP0_RST;
      m_map1 = opmc_pkg::MAP1_RST;
   endfunction
   function automatic logic [1:0] tgt();
      if (!(vs_op | vdd_lop) || (din == 2'h0 && !idle_pin)) return opmc_pkg::M_SLEEP;
      if (!idle_pin) return opmc_pkg::M_LIMP;
      if (din != 2'h0) return opmc_pkg::M_ACTIVE;
      if (!vdd_uv && (m_out != 8'h0 || (m_mode == opmc_pkg::M_ACTIVE && m_act))) return opmc_pkg::M_ACTIVE;
      return opmc_pkg::M_IDLE;
   endfunction
   task automatic go;
      logic ok;
      @(posedge hclk);
      m_mode = tgt();
      if (vdd_uv || !idle_pin || m_mode == opmc_pkg::M_SLEEP) regs_def();
      u_host.settle(m_mode, ok);
      check({30'h0, mode_status}, {30'h0, m_mode});
      pm = (din[0] ? m_map0 : 8'h0) | (din[1] ? m_map1 : 8'h0);
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      if (m_mode == opmc_pkg::M_ACTIVE)
         check({24'h0, channel_on}, {24'h0, (vdd_uv ? 8'h0 : m_out) | ((vs_uv & vdd_uv) ? 8'h0 : pm)});
      else if (m_mode == opmc_pkg::M_LIMP)
         check({24'h0, channel_on}, {24'h0, pm});
      else
         check({24'h0, channel_on}, 32'h0);
      @(posedge hclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      u_host.xfer(1'b1, a, d, q);
      if ((m_mode == opmc_pkg::M_IDLE || m_mode == opmc_pkg::M_ACTIVE) && !vdd_uv) begin
         if (a == opmc_pkg::ADDR_OUT) m_out = d[7:0];
         if (a == opmc_pkg::ADDR_HWCR) m_act = d[0];
         if (a == opmc_pkg::ADDR_MAP0) m_map0 = d[7:0];
         if (a == opmc_pkg::ADDR_MAP1) m_map1 = d[7:0];
         if (a == opmc_pkg::ADDR_HWCR && d[1]) regs_def();
         if (a == opmc_pkg::ADDR_ERR) m_err = m_err & ~d[7:0];
      end
   endtask
   task automatic rd(input logic [7:0] a);
      logic [31:0] q, e;
      u_host.xfer(1'b0, a, 32'h0, q);
      case (a)
         opmc_pkg::ADDR_OUT:  e = {24'h0, m_out};
         opmc_pkg::ADDR_HWCR: e = {31'h0, m_act};
         opmc_pkg::ADDR_MAP0: e = {24'h0, m_map0};
         opmc_pkg::ADDR_MAP1: e = {24'h0, m_map1};
         opmc_pkg::ADDR_STAT: e = {27'h0, vs_uv, vdd_uv, vs_op | vdd_lop, m_mode};
         opmc_pkg::ADDR_ERR:  e = {24'h0, m_err};
         default:             e = 32'h0;
      endcase
      if (m_mode == opmc_pkg::M_SLEEP || vdd_uv) e = 32'h0;
      check(q, e);
      check({31'h0, hresp}, 32'h0);
   endtask
   task automatic fault(input logic [7:0] b);
      evt <= b;
      repeat (6) @(posedge hclk);
      if (m_mode == opmc_pkg::M_ACTIVE || m_mode == opmc_pkg::M_LIMP) m_err = m_err | b;
      evt <= 8'h0;
      repeat (6) @(posedge hclk);
   endtask
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      {vs_uv, vdd_uv, vs_op, vdd_lop} = 4'h3;
      evt = 8'h0;
      cyc = 0;
      fail_count = 0;
      samples_checked = 0;
      x = 32'hC445;
      m_err = 8'h0;
      m_mode = opmc_pkg::M_SLEEP;
      regs_def();
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      go();
      rd(opmc_pkg::ADDR_OUT);
      u_host.pins(1'b1, 2'h0);
      go();
      wr(opmc_pkg::ADDR_MAP0, rnd());
      rd(opmc_pkg::ADDR_MAP0);
      rd(8'h18);
      wr(opmc_pkg::ADDR_STAT, 32'hFFFFFFFF);
      rd(opmc_pkg::ADDR_STAT);
      fault(8'h10);
      rd(opmc_pkg::ADDR_ERR);
      wr(opmc_pkg::ADDR_OUT, rnd() | 32'h1);
      repeat (3) @(negedge hclk) check({30'h0, mode_status}, {30'h0, opmc_pkg::M_IDLE});
      @(posedge hclk);
      go();
      fault(8'h20);
      wr(opmc_pkg::ADDR_OUT, 32'h0);
      go();
      rd(opmc_pkg::ADDR_ERR);
      wr(opmc_pkg::ADDR_ERR, 32'h20);
      rd(opmc_pkg::ADDR_ERR);
      wr(opmc_pkg::ADDR_HWCR, 32'h1);
      wr(opmc_pkg::ADDR_OUT, 32'h1);
      go();
      wr(opmc_pkg::ADDR_OUT, 32'h0);
      go();
      wr(opmc_pkg::ADDR_MAP0, 32'h0);
      wr(opmc_pkg::ADDR_MAP1, 32'h0);
      wr(opmc_pkg::ADDR_HWCR, 32'h0);
      go();
      u_host.pins(1'b1, 2'h1);
      go();
      u_host.pins(1'b1, 2'h0);
      go();
      wr(opmc_pkg::ADDR_HWCR, 32'h1);
      wr(opmc_pkg::ADDR_OUT, rnd() | 32'h2);
      go();
      vdd_uv <= 1'b1;
      go();
      rd(opmc_pkg::ADDR_OUT);
      vdd_uv <= 1'b0;
      u_host.pins(1'b1, 2'h2);
      go();
      vdd_uv <= 1'b1;
      go();
      vs_uv <= 1'b1;
      go();
      {vs_uv, vdd_uv} <= 2'h0;
      u_host.pins(1'b0, 2'h1);
      go();
      wr(opmc_pkg::ADDR_MAP0, 32'hFF);
      rd(opmc_pkg::ADDR_MAP0);
      rd(opmc_pkg::ADDR_STAT);
      u_host.pins(1'b0, 2'h0);
      go();
      u_host.pins(1'b1, 2'h0);
      go();
      wr(opmc_pkg::ADDR_MAP1, rnd());
      wr(opmc_pkg::ADDR_HWCR, 32'h2);
      rd(opmc_pkg::ADDR_MAP1);
      {vs_op, vdd_lop} <= 2'h0;
      go();
      vdd_lop <= 1'b1;
      go();
      complete_run();
   end
endmodule
`default_nettype wire
